// >>> shared/cdcl_regs.vh
`ifndef CDCL_REGS_VH
`define CDCL_REGS_VH

// ==========================================================
// Register byte offsets.
`define CDCL_OFF_CTRL 8'h00
`define CDCL_OFF_STATUS 8'h04
`define CDCL_OFF_LOADCNT 8'h08
`define CDCL_OFF_STAGE1 8'h10
`define CDCL_OFF_STAGE2 8'h30
// Word index of each single register and of the first register of each channel bank.
`define CDCL_IDX_CTRL 6'h00
`define CDCL_IDX_STATUS 6'h01
`define CDCL_IDX_LOADCNT 6'h02
`define CDCL_IDX_STAGE1 6'h04
`define CDCL_IDX_STAGE2 6'h0c

// ==========================================================
// Control register fields and reset value.
`define CDCL_CTRL_SOFT_POWER_DOWN_INPUT 0
`define CDCL_CTRL_LOAD_HOLD 1
`define CDCL_CTRL_RST 2'h0

// ==========================================================
// Status register fields.
`define CDCL_ST_SEQ_ACTIVE 0
`define CDCL_ST_XFR_PEND 1
`define CDCL_ST_STANDBY 2
`define CDCL_ST_SEQ_DIR 3
`define CDCL_ST_SEQ_CNT_LO 4
`define CDCL_ST_LAST_CH_LO 8

// ==========================================================
// Channel address codes and sequencer ends.
`define CDCL_SEQ_ADDR 3'h7
`define CDCL_FIRST_CH 3'h0
`define CDCL_LAST_CH 3'h5
`define CDCL_CNT_STEP 3'h1

// ==========================================================
// Miscellaneous widths and reset values.
`define CDCL_LOADCNT_W 16
`define CDCL_ZERO32 32'h0000_0000

`endif

// >>> core/cdcl_latch_bank.v
`timescale 1ns/10ps

// ==========================================================
// First-stage channel latches: one write port, a parallel view
// of all words for the transfer, and a registered read port.
module cdcl_latch_bank #(
  parameter WIDTH = 10,
  parameter DEPTH = 6
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire clear_in,
  input wire wr_en_in,
  input wire [2:0] wr_addr_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire [2:0] rd_addr_in,
  output reg [WIDTH-1:0] rd_data_out,
  output reg [WIDTH*DEPTH-1:0] all_out
);

  integer i;

  // Clear wins over a write so standby always empties the bank.
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      all_out <= {(WIDTH*DEPTH){1'b0}};
    end
    else if (clear_in)
    begin
      all_out <= {(WIDTH*DEPTH){1'b0}};
    end
    else
    begin
      for (i = 0; i < DEPTH; i = i + 1)
      begin
        if (wr_en_in && (wr_addr_in == i[2:0]))
        begin
          all_out[i*WIDTH +: WIDTH] <= wr_data_in;
        end
      end
    end
  end

  // Registered read port; out-of-range addresses read as zero.
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_data_out <= {WIDTH{1'b0}};
    end
    else
    begin
      rd_data_out <= {WIDTH{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
      begin
        if (rd_addr_in == i[2:0])
        begin
          rd_data_out <= all_out[i*WIDTH +: WIDTH];
        end
      end
    end
  end

endmodule // cdcl_latch_bank

// >>> core/cdcl_channel_loader.v
`timescale 1ns/10ps
`include "cdcl_regs.vh"

module cdcl_channel_loader #(
  parameter WORD_W = 10,
  parameter NUM_CH = 6
) (
  input wire core_clk_in,
  input wire rst_b_in,
  // Classic Wishbone slave.
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [7:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  // Timing controller side, sampled on core_clk_in.
  input wire pixel_clk_in,
  input wire [WORD_W-1:0] pixel_word_inputs_in,
  input wire [2:0] chan_addr_in,
  input wire start_or_select_strobe_in,
  input wire load_direction_in,
  input wire edge_phase_select_in,
  input wire polarity_select_in,
  input wire output_transfer_strobe_in,
  input wire power_down_input_in,
  // Second-stage outputs.
  output reg [WORD_W*NUM_CH-1:0] channel_code_out,
  output reg [WORD_W*NUM_CH-1:0] level_offset_out,
  output reg above_mid_out
);

  // ==========================================================
  // Helper functions.

  // True for a code that names a real channel latch.
  function chan_valid;
    input [2:0] addr;
    begin
      chan_valid = (addr <= `CDCL_LAST_CH);
    end
  endfunction

  // Next sequencer count in the chosen direction.
  function [2:0] seq_step;
    input [2:0] cnt;
    input down;
    begin
      if (down)
        seq_step = cnt - `CDCL_CNT_STEP;
      else
        seq_step = cnt + `CDCL_CNT_STEP;
    end
  endfunction

  // ==========================================================
  // Declarations.
  reg pclk_q;
  reg strobe_q;
  reg [2:0] addr_q;
  reg cs_q;
  reg seq_active_q;
  reg seq_down_q;
  reg [2:0] seq_cnt_q;
  reg xfr_pend_q;
  reg [2:0] last_ch_q;
  reg [`CDCL_LOADCNT_W-1:0] load_cnt_q;
  reg [1:0] ctrl_q;
  reg req_q;
  wire rise_w;
  wire fall_w;
  wire load_edge_w;
  wire [2:0] sel_addr_w;
  wire sel_cs_w;
  wire power_down_input_w;
  wire start_w;
  wire addr_load_w;
  wire seq_load_w;
  wire wr_en_w;
  wire [2:0] wr_addr_w;
  wire [2:0] rd_addr_w;
  wire [WORD_W-1:0] rd_data_w;
  wire [WORD_W*NUM_CH-1:0] stage1_w;
  wire [5:0] idx_w;
  wire [5:0] rd_off_w;
  wire bus_go_w;
  wire bus_fin_w;
  wire [31:0] status_w;
  reg [31:0] rd_mux_w;
  integer k;

  // ==========================================================
  // Pixel clock edge detection.

  // The pixel clock is a sampled input; its edges become pulses.
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pclk_q <= 1'b0;
    else
      pclk_q <= pixel_clk_in;
  end

  assign rise_w = pixel_clk_in & ~pclk_q;
  assign fall_w = ~pixel_clk_in & pclk_q;

  assign load_edge_w = edge_phase_select_in ? rise_w : fall_w;

  assign power_down_input_w = power_down_input_in | ctrl_q[`CDCL_CTRL_SOFT_POWER_DOWN_INPUT];

  // ==========================================================
  // Address and select sampling at each rising pixel edge.

  // Address, select and strobe history held from the last rise.
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      addr_q <= `CDCL_FIRST_CH;
      cs_q <= 1'b0;
      strobe_q <= 1'b0;
    end
    else if (rise_w)
    begin
      addr_q <= chan_addr_in;
      cs_q <= start_or_select_strobe_in;
      strobe_q <= start_or_select_strobe_in;
    end
  end

  assign sel_addr_w = edge_phase_select_in ? chan_addr_in : addr_q;
  assign sel_cs_w = edge_phase_select_in ? start_or_select_strobe_in : cs_q;

  // ==========================================================
  // Load decisions.

  assign start_w = rise_w & (chan_addr_in == `CDCL_SEQ_ADDR) &
                   start_or_select_strobe_in & ~strobe_q & ~power_down_input_w;

  assign addr_load_w = load_edge_w & sel_cs_w & chan_valid(sel_addr_w) &
                       ~power_down_input_w & ~ctrl_q[`CDCL_CTRL_LOAD_HOLD];

  assign seq_load_w = load_edge_w & (sel_addr_w == `CDCL_SEQ_ADDR) &
                      seq_active_q & ~start_w & ~power_down_input_w &
                      ~ctrl_q[`CDCL_CTRL_LOAD_HOLD];

  assign wr_en_w = addr_load_w | seq_load_w;
  assign wr_addr_w = seq_load_w ? seq_cnt_q : sel_addr_w;

  // ==========================================================
  // Internal sequencer.

  // Arms on a start pulse, steps on each sequenced load except the one at the end channel, which disarms it.
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      seq_active_q <= 1'b0;
      seq_down_q <= 1'b0;
      seq_cnt_q <= `CDCL_FIRST_CH;
    end
    else if (power_down_input_w)
    begin
      seq_active_q <= 1'b0;
      seq_cnt_q <= `CDCL_FIRST_CH;
    end
    else if (start_w)
    begin
      seq_active_q <= 1'b1;
      seq_down_q <= load_direction_in;
      seq_cnt_q <= load_direction_in ? `CDCL_LAST_CH : `CDCL_FIRST_CH;
    end
    else if (seq_load_w)
    begin
      if (seq_cnt_q == (seq_down_q ? `CDCL_FIRST_CH : `CDCL_LAST_CH))
        seq_active_q <= 1'b0;
      else
        seq_cnt_q <= seq_step(seq_cnt_q, seq_down_q);
    end
  end

  // ==========================================================
  // First-stage latches.
  cdcl_latch_bank #(
    .WIDTH(WORD_W),
    .DEPTH(NUM_CH)
  ) u_bank (
    .clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .clear_in(power_down_input_w),
    .wr_en_in(wr_en_w),
    .wr_addr_in(wr_addr_w),
    .wr_data_in(pixel_word_inputs_in),
    .rd_addr_in(rd_addr_w),
    .rd_data_out(rd_data_w),
    .all_out(stage1_w)
  );

  // ==========================================================
  // Transfer to the second stage.

  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      xfr_pend_q <= 1'b0;
      channel_code_out <= {(WORD_W*NUM_CH){1'b0}};
      level_offset_out <= {(WORD_W*NUM_CH){1'b0}};
    end
    else if (power_down_input_w)
    begin
      xfr_pend_q <= 1'b0;
      channel_code_out <= {(WORD_W*NUM_CH){1'b0}};
      level_offset_out <= {(WORD_W*NUM_CH){1'b0}};
    end
    else if (rise_w)
    begin
      xfr_pend_q <= output_transfer_strobe_in;
    end
    else if (fall_w && xfr_pend_q)
    begin
      xfr_pend_q <= 1'b0;
      channel_code_out <= stage1_w;
      level_offset_out <= ~stage1_w;
    end
  end

  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      above_mid_out <= 1'b0;
    else
      above_mid_out <= polarity_select_in;
  end

  // Load bookkeeping visible to software.
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      last_ch_q <= `CDCL_FIRST_CH;
      load_cnt_q <= {`CDCL_LOADCNT_W{1'b0}};
    end
    else if (wr_en_w)
    begin
      last_ch_q <= wr_addr_w;
      load_cnt_q <= load_cnt_q + {{(`CDCL_LOADCNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // Wishbone slave.

  // A request is seen, then answered one edge later.
  assign bus_go_w = wb_cyc_in & wb_stb_in & ~req_q & ~wb_ack_out;
  assign bus_fin_w = req_q;
  assign idx_w = wb_adr_in[7:2];
  assign rd_off_w = (idx_w >= `CDCL_IDX_STAGE2) ?
                    idx_w - `CDCL_IDX_STAGE2 : idx_w - `CDCL_IDX_STAGE1;
  assign rd_addr_w = rd_off_w[2:0];

  assign status_w = {16'h0000, 4'h0, 1'b0, last_ch_q, 1'b0, seq_cnt_q,
                     seq_down_q, power_down_input_w, xfr_pend_q, seq_active_q};

  // Read data selection; unmapped words read as zero.
  always @*
  begin
    rd_mux_w = `CDCL_ZERO32;
    if (idx_w == `CDCL_IDX_CTRL)
      rd_mux_w = {30'h0000_0000, ctrl_q};
    else if (idx_w == `CDCL_IDX_STATUS)
      rd_mux_w = status_w;
    else if (idx_w == `CDCL_IDX_LOADCNT)
      rd_mux_w = {16'h0000, load_cnt_q};
    else if ((idx_w >= `CDCL_IDX_STAGE1) && (rd_addr_w < NUM_CH) &&
             (idx_w < `CDCL_IDX_STAGE2))
      rd_mux_w = {22'h00_0000, rd_data_w};
    else
      for (k = 0; k < NUM_CH; k = k + 1)
        if (idx_w == `CDCL_IDX_STAGE2 + k[5:0])
          rd_mux_w = {22'h00_0000, channel_code_out[k*WORD_W +: WORD_W]};
  end

  // Handshake, write and read data register.
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      req_q <= 1'b0;
      wb_ack_out <= 1'b0;
      wb_dat_out <= `CDCL_ZERO32;
      ctrl_q <= `CDCL_CTRL_RST;
    end
    else
    begin
      req_q <= bus_go_w;
      wb_ack_out <= bus_fin_w;
      if (bus_fin_w && !wb_we_in)
        wb_dat_out <= rd_mux_w;
      // A write lands only at the edge where the master sees ack high.
      if (wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0] &&
          (wb_adr_in == `CDCL_OFF_CTRL))
        ctrl_q <= wb_dat_in[1:0];
    end
  end

endmodule // cdcl_channel_loader

// >>> test/cdcl_loader_asserts.sv
`timescale 1ns/10ps
// ==========
// Port checks for the channel loader.
module cdcl_loader_asserts #(
  parameter WORD_W = 10,
  parameter NUM_CH = 6
) (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [7:0] wb_adr_in,
  input wire [31:0] wb_dat_out,
  input wire wb_ack_out,
  input wire polarity_select_in,
  input wire output_transfer_strobe_in,
  input wire power_down_input_in,
  input wire [WORD_W*NUM_CH-1:0] channel_code_out,
  input wire [WORD_W*NUM_CH-1:0] level_offset_out,
  input wire above_mid_out
);
  reg [4:0] quiet_q;
  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Quiet cycles since a transfer, standby or bus write, saturating.
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      quiet_q <= 5'h00;
    else if (output_transfer_strobe_in || power_down_input_in || wb_we_in)
      quiet_q <= 5'h00;
    else if (quiet_q != 5'h1f)
      quiet_q <= quiet_q + 5'h01;
  end
  // A request is its rising strobe.
  sequence req_s;
    $rose(wb_cyc_in && wb_stb_in);
  endsequence
  wb_answer_a: assert property (req_s |-> ##[1:2] wb_ack_out)
    else $error("bus answer late");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  ack_held_a: assert property (wb_ack_out |-> wb_cyc_in && wb_stb_in)
    else $error("ack without request");
  unmap_zero_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in[7:2] > 6'h11
    |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  codes_hold_a: assert property ($changed(channel_code_out) |-> quiet_q < 5'h0c)
    else $error("codes moved without transfer");
  power_down_input_clear_a: assert property (power_down_input_in [*3] |-> channel_code_out == '0)
    else $error("standby kept codes");
  offset_code_a: assert property ($stable(channel_code_out) |->
    channel_code_out[9:0] == 10'h000 || level_offset_out[9:0] == 10'h3ff - channel_code_out[9:0])
    else $error("offset not code distance");
  mid_side_a: assert property ($past(rst_b_in) |->
    above_mid_out == $past(polarity_select_in)) else $error("mid side wrong");
endmodule // cdcl_loader_asserts

bind cdcl_channel_loader cdcl_loader_asserts #(.WORD_W(WORD_W), .NUM_CH(NUM_CH)) u_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .polarity_select_in(polarity_select_in),
  .output_transfer_strobe_in(output_transfer_strobe_in),
  .power_down_input_in(power_down_input_in), .channel_code_out(channel_code_out),
  .level_offset_out(level_offset_out), .above_mid_out(above_mid_out));

// >>> test/cdcl_tc_model.sv
`timescale 1ns/10ps
// ==========
// Timing controller model: free-running pixel clock and words.
module cdcl_tc_model (
  input wire core_clk_in,
  input wire rst_b_in,
  output reg pixel_clk_out,
  output reg [9:0] pixel_word_out
);
  reg [2:0] phase_q;
  // Each level lasts four core cycles; words move mid-level so both edges see them settled.
  // word steady at edges
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      phase_q <= 3'h0;
      pixel_clk_out <= 1'b0;
      pixel_word_out <= 10'h2a5;
    end
    else
    begin
      phase_q <= phase_q + 3'h1;
      pixel_clk_out <= phase_q[2];
      if (phase_q[1:0] == 2'h2)
        pixel_word_out <= {pixel_word_out[8:0], pixel_word_out[9] ^ pixel_word_out[6]};
    end
  end
endmodule // cdcl_tc_model

// >>> test/tb_cdcl_channel_loader.sv
`timescale 1ns/10ps
`include "cdcl_regs.vh"
// ==========
// Self-checking bench for the channel loader.
module tb_cdcl_channel_loader;
  reg clk, rst_b, cyc, stb, we, cs, dir, ph, pol, output_transfer_strobe, pd;
  reg [7:0] adr;
  reg [31:0] wdat, rd, seed;
  reg [2:0] addr;
  reg [9:0] wr, wf;
  reg [9:0] e [0:6];
  wire [31:0] rdat;
  wire ack, pclk, amid;
  wire [9:0] word;
  wire [59:0] code, offs;
  integer failures, checks_done, cycles, k, d;
  // Device and its timing controller.
  cdcl_channel_loader u_dut (.core_clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .pixel_clk_in(pclk), .pixel_word_inputs_in(word),
    .chan_addr_in(addr), .start_or_select_strobe_in(cs), .load_direction_in(dir),
    .edge_phase_select_in(ph), .polarity_select_in(pol), .output_transfer_strobe_in(output_transfer_strobe),
    .power_down_input_in(pd), .channel_code_out(code), .level_offset_out(offs),
    .above_mid_out(amid));
  cdcl_tc_model u_tc (.core_clk_in(clk), .rst_b_in(rst_b), .pixel_clk_out(pclk),
    .pixel_word_out(word));
  // Core clock of 40 ns.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Cycle ceiling against a hung wait.
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      results;
    end
  end
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function integer ch_of(input integer i, input integer dn);
    ch_of = dn ? 5 - i : i;
  endfunction
  function [9:0] off(input [9:0] c);
    off = 10'h3ff - c;
  endfunction
  function [7:0] s1(input integer i);
    s1 = `CDCL_OFF_STAGE1 + {i[5:0], 2'b00};
  endfunction
  task cmp(input string n, input [63:0] x, input [63:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== x)
      begin
        failures = failures + 1;
        $display("Error %s expected %h seen %h", n, x, g);
      end
    end
  endtask
  // One classic bus cycle; a read is compared with x.
  task wb(input w, input [7:0] a, input [31:0] dd, input [63:0] x);
    begin
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, dd};
      @(posedge clk);
      while (ack !== 1'b1)
        @(posedge clk);
      rd = rdat;
      {cyc, stb} <= 2'b00;
      if (!w)
        cmp("reg", x, {32'h0, rd});
      @(posedge clk);
    end
  endtask
  // Wait for the core edge that sees the pixel clock reach v.
  task pedge(input v);
    reg pp;
    begin
      pp = pclk;
      @(posedge clk);
      while (pclk === pp || pclk !== v)
      begin
        pp = pclk;
        @(posedge clk);
      end
    end
  endtask
  // controls held from fall to fall
  task pstep(input [2:0] a, input s, input x);
    begin
      {addr, cs, output_transfer_strobe} <= {a, s, x};
      pedge(1'b1);
      wr = word;
      pedge(1'b0);
      wf = word;
    end
  endtask
  task results;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Main sequence.
  initial
  begin
    {rst_b, cyc, stb, we, cs, dir, ph, pol, output_transfer_strobe, pd} = 10'h000;
    {adr, wdat, addr, seed} = {8'h00, 32'h0, 3'h6, 32'h189b};
    {failures, checks_done, cycles} = 96'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    cmp("code", 64'h0, code);
    wb(1'b0, `CDCL_OFF_CTRL, 32'h0, 64'h0);
    wb(1'b0, 8'hfc, 32'h0, 64'h0);
    $display("test reset done");
    pedge(1'b0);
    for (k = 0; k < 6; k = k + 1)
    begin
      pstep(k[2:0], 1'b1, 1'b0);
      e[k] = wf;
    end
    k = rnd() % 6;
    pstep(k[2:0], 1'b0, 1'b0);
    pstep(3'h6, 1'b1, 1'b0);
    for (k = 0; k < 6; k = k + 1)
      wb(1'b0, s1(k), 32'h0, e[k]);
    $display("test addressed done");
    for (d = 0; d < 2; d = d + 1)
    begin
      rd = rnd();
      {dir, pol} <= {d[0], d[0] ^ rd[0]};
      pedge(1'b0);
      pstep(`CDCL_SEQ_ADDR, 1'b0, 1'b0);
      for (k = 0; k < 6; k = k + 1)
      begin
        pstep(`CDCL_SEQ_ADDR, 1'b1, 1'b0);
        e[ch_of(k, d)] = wf;
      end
      pstep(`CDCL_SEQ_ADDR, 1'b1, 1'b0);
      pstep(3'h6, 1'b1, 1'b1);
      repeat (2) @(posedge clk);
      for (k = 0; k < 6; k = k + 1)
      begin
        cmp("code", e[k], code[10*k+:10]);
        cmp("offset", off(e[k]), offs[10*k+:10]);
        wb(1'b0, s1(k), 32'h0, e[k]);
      end
      cmp("above", pol, amid);
      $display("test sequence done");
    end
    ph <= 1'b1;
    pedge(1'b0);
    pstep(3'h3, 1'b1, 1'b0);
    e[3] = wr;
    pstep(3'h6, 1'b1, 1'b0);
    ph <= 1'b0;
    wb(1'b0, s1(3), 32'h0, e[3]);
    {ph, dir} <= 2'b10;
    pstep(`CDCL_SEQ_ADDR, 1'b0, 1'b0);
    for (k = 0; k < 7; k = k + 1)
    begin
      pstep(`CDCL_SEQ_ADDR, 1'b1, 1'b0);
      e[k] = wr;
    end
    pstep(3'h6, 1'b1, 1'b0);
    ph <= 1'b0;
    for (k = 0; k < 6; k = k + 1)
      wb(1'b0, s1(k), 32'h0, e[k + 1]);
    pd <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("code", 64'h0, code);
    pd <= 1'b0;
    wb(1'b0, s1(0), 32'h0, 64'h0);
    pedge(1'b0);
    pstep(3'h1, 1'b1, 1'b0);
    e[1] = wf;
    pstep(3'h6, 1'b1, 1'b0);
    wb(1'b0, s1(1), 32'h0, e[1]);
    wb(1'b0, `CDCL_OFF_LOADCNT, 32'h0, 64'h1a);
    wb(1'b1, `CDCL_OFF_CTRL, 32'h1, 64'h0);
    wb(1'b0, `CDCL_OFF_CTRL, 32'h0, 64'h1);
    wb(1'b0, s1(1), 32'h0, 64'h0);
    wb(1'b1, `CDCL_OFF_CTRL, 32'h2, 64'h0);
    pedge(1'b0);
    pstep(3'h2, 1'b1, 1'b0);
    pstep(3'h6, 1'b1, 1'b0);
    wb(1'b0, s1(2), 32'h0, 64'h0);
    wb(1'b1, `CDCL_OFF_CTRL, 32'h0, 64'h0);
    $display("test standby done");
    results;
  end
endmodule // tb_cdcl_channel_loader
